// File: hw/pwr_seq_map.vh
// Register map, fields and timing constants of the power-down sequencer
`ifndef PWR_SEQ_MAP_VH
`define PWR_SEQ_MAP_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_POWER_CONTROL 12'h000
`define ADDR_CLOCK_SYNTH 12'h004
`define ADDR_IRQ_ENABLE2 12'h008
`define ADDR_STATUS 12'h00C
`define ADDR_WAKE_EVENT 12'h010
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PCTL_PD_REQ 1
`define PCTL_SERIAL_WAKE 3
`define PCTL_EXT0_WAKE 5
`define PLL_LOCK_BIT 6
`define PLL_OSC_SLEEP 7
`define PLL_DIV_LSB 0
`define PLL_DIV_W 3
`define IE2_INTERVAL_EN 2
`define IE2_SPI_EN 0
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_POWER_CONTROL 8'h00
`define RST_CLOCK_SYNTH 8'h03
`define RST_IRQ_ENABLE2 8'hA0
// ----------------------------------------
// Timing, in microseconds, and clock rate
// ----------------------------------------
`define CORE_CLK_HZ 10000000
`define POR_DELAY_US 128000
`define PLL_LOCK_US 1000
`define XTAL_START_US 150000
`endif

// File: hw/delay_timer.v
// Down counter that reports when a loaded delay has elapsed
`timescale 1ns/1ps
module delay_timer #(
    parameter W = 24
) (
    // Clock and reset
    input wire core_clk,
    input wire rst_b,
    // Control
    input wire start,
    input wire [W-1:0] load,
    // Status
    output reg busy,
    output reg done
);
    reg [W-1:0] count;

    always @(posedge core_clk) begin
        if (!rst_b) begin
            count <= {W{1'b0}};
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                count <= load;
                busy <= 1'b1;
            end else if (busy) begin
                if (count <= {{(W-1){1'b0}}, 1'b1}) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count <= count - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

// File: hw/power_down_wake_sequencer.v
// Power-down entry, wake-up and power-on reset release sequencer
// ----------------------------------------
// Operation
// RULE_01: Setting the power-down request bit enters full power-down.
// RULE_02: Power-down stops the PLL output and the core clock.
// RULE_03: Oscillator halts in power-down only when oscillator sleep bit set.
// RULE_04: Only the enabled interval counter stays clocked in power-down.
// RULE_05: Ports hold levels, DAC floats, ALE and fetch strobe low.
// RULE_06: Reset pin ends power-down, defaults registers, restarts at vector.
// RULE_07: Power cycle restores defaults and restarts after about 128 ms.
// RULE_08: Interval counter interrupt wakes when oscillator kept and enabled.
// RULE_09: With serial wake enable set, enabled SPI interrupt wakes device.
// RULE_10: With ext irq zero wake enable set, enabled ext irq zero wakes.
// RULE_11: Return from interrupt resumes after the power-down instruction.
// RULE_12: After wake with oscillator running, PLL needs about 1 ms.
// RULE_13: Software should poll the lock flag, bit 6, before timing work.
// RULE_14: A halted oscillator adds about 150 ms start-up before lock.
// RULE_15: 3 V part holds reset below 2.63 V, then 128 ms timer.
// RULE_16: 5 V part holds reset below 4.5 V, then 128 ms timer.
// RULE_17: On supply decay, reset holds until supply falls below 1 V.
// RULE_18: Core clock divided by the divider field as a lower-power option.
// RULE_19: Interval counter interrupt gated by its own enable bit.
// RULE_20: Lock flag clears when PLL stops, sets once relocked after wake.
// ----------------------------------------
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "pwr_seq_map.vh"
module power_down_wake_sequencer #(
    parameter POR_CYCLES =
        (`CORE_CLK_HZ / 1000000) * `POR_DELAY_US,
    parameter LOCK_CYCLES =
        (`CORE_CLK_HZ / 1000000) * `PLL_LOCK_US,
    parameter XTAL_CYCLES =
        (`CORE_CLK_HZ / 1000000) * `XTAL_START_US,
    parameter TW = 24
) (
    // Clock and reset
    input wire core_clk,
    input wire rst_b,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    // Supply detectors and reset pin
    input wire reset_pin_b,
    input wire supply_above_threshold,
    input wire supply_above_1v,
    // Wake sources
    input wire interval_counter_irq,
    input wire spi_irq,
    input wire external_irq_zero,
    input wire ext0_irq_enable,
    // Core side
    input wire core_reti,
    output reg core_reset,
    output reg wake_irq_pending,
    output reg [2:0] wake_source,
    output reg resume_after_pd,
    // Clock gating
    output reg pll_run,
    output reg core_clk_enable,
    output reg osc_run,
    output reg interval_counter_clk_en,
    output reg peripheral_clk_en,
    output reg [`PLL_DIV_W-1:0] core_clock_divider,
    // Pin control in power-down
    output reg port_hold,
    output reg dac_out_enable,
    output reg ale_force_low,
    output reg program_fetch_strobe_force_low
);
    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam S_POR = 3'd0;
    localparam S_RUN = 3'd1;
    localparam S_PD = 3'd2;
    localparam S_XTAL = 3'd3;
    localparam S_LOCK = 3'd4;
    localparam S_PINRST = 3'd5;
    localparam [7:0] SYNTH_RESET = `RST_CLOCK_SYNTH;

    reg [2:0] state;
    reg [7:0] power_control_reg;
    reg [7:0] clock_synth_control_reg;
    reg [7:0] irq_enable2;
    reg pll_locked;
    reg osc_stopped;
    reg timer_start;
    reg [TW-1:0] timer_load;
    wire timer_busy;
    wire timer_done;

    wire oscillator_sleep_bit = clock_synth_control_reg[`PLL_OSC_SLEEP];
    wire serial_wake_enable = power_control_reg[`PCTL_SERIAL_WAKE];
    wire ext_irq_zero_wake_enable = power_control_reg[`PCTL_EXT0_WAKE];
    wire interval_irq_enable = irq_enable2[`IE2_INTERVAL_EN];
    wire spi_irq_enable = irq_enable2[`IE2_SPI_EN];

    // ----------------------------------------
    // Wake decode
    // ----------------------------------------
    wire wake_interval = !oscillator_sleep_bit && interval_irq_enable &&
        interval_counter_irq; // see RULE_08 see RULE_19
    wire wake_spi = serial_wake_enable && spi_irq_enable &&
        spi_irq; // see RULE_09
    wire wake_ext0 = ext_irq_zero_wake_enable && ext0_irq_enable &&
        external_irq_zero; // see RULE_10
    wire wake_any = wake_interval || wake_spi || wake_ext0;

    // Supply loss overrides everything; reset held until below 1 V too
    wire supply_bad = !supply_above_threshold; // see RULE_15 see RULE_16

    // ----------------------------------------
    // APB slave, zero wait states
    // ----------------------------------------
    wire apb_access = psel && penable;
    wire apb_write = apb_access && pwrite;
    wire addr_ok = (paddr == `ADDR_POWER_CONTROL) ||
        (paddr == `ADDR_CLOCK_SYNTH) || (paddr == `ADDR_IRQ_ENABLE2) ||
        (paddr == `ADDR_STATUS) || (paddr == `ADDR_WAKE_EVENT);
    assign pready = 1'b1;
    assign pslverr = apb_access && !addr_ok;

    // Read word latched in the setup cycle, so it stands through access
    always @(posedge core_clk) begin
        if (!rst_b) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable) begin
            case (paddr)
                `ADDR_POWER_CONTROL:
                    prdata <= {24'h000000, power_control_reg};
                `ADDR_CLOCK_SYNTH:
                    prdata <= {24'h000000, clock_synth_control_reg[7],
                        pll_locked, // see RULE_13
                        clock_synth_control_reg[5:0]};
                `ADDR_IRQ_ENABLE2: prdata <= {24'h000000, irq_enable2};
                `ADDR_STATUS: prdata <= {29'h00000000, state};
                `ADDR_WAKE_EVENT: prdata <= {29'h00000000, wake_source};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    delay_timer #(
        .W(TW)
    ) u_timer (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .start(timer_start),
        .load(timer_load),
        .busy(timer_busy),
        .done(timer_done)
    );

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always @(posedge core_clk) begin
        if (!rst_b) begin
            state <= S_POR;
            power_control_reg <= `RST_POWER_CONTROL;
            clock_synth_control_reg <= `RST_CLOCK_SYNTH;
            irq_enable2 <= `RST_IRQ_ENABLE2;
            pll_locked <= 1'b0;
            osc_stopped <= 1'b0;
            timer_start <= 1'b0;
            timer_load <= {TW{1'b0}};
            core_reset <= 1'b1;
            wake_irq_pending <= 1'b0;
            wake_source <= 3'b000;
            resume_after_pd <= 1'b0;
        end else begin
            timer_start <= 1'b0;
            if (apb_write && state == S_RUN) begin
                case (paddr)
                    `ADDR_POWER_CONTROL:
                        power_control_reg <= pwdata[7:0];
                    `ADDR_CLOCK_SYNTH:
                        clock_synth_control_reg <= {pwdata[7], 1'b0,
                            pwdata[5:0]};
                    `ADDR_IRQ_ENABLE2: irq_enable2 <= pwdata[7:0];
                    default: ;
                endcase
            end
            // Core acknowledges the wake interrupt; set wins over clear
            if (core_reti && !(state == S_PD && wake_any)) begin
                wake_irq_pending <= 1'b0; // see RULE_11
            end
            case (state)
                S_POR: begin
                    core_reset <= 1'b1;
                    // Timer restarts whenever the supply dips
                    if (supply_bad || !supply_above_1v) begin
                        timer_start <= 1'b1;
                        timer_load <= POR_CYCLES[TW-1:0]; // see RULE_07
                    end else if (timer_done && !timer_start) begin
                        core_reset <= 1'b0;
                        state <= S_LOCK;
                        timer_start <= 1'b1;
                        timer_load <= LOCK_CYCLES[TW-1:0];
                    end else if (!timer_busy && !timer_start) begin
                        timer_start <= 1'b1;
                        timer_load <= POR_CYCLES[TW-1:0]; // see RULE_07
                    end
                end
                S_RUN: begin
                    if (apb_write && paddr == `ADDR_POWER_CONTROL &&
                            pwdata[`PCTL_PD_REQ]) begin
                        state <= S_PD; // see RULE_01
                        pll_locked <= 1'b0; // see RULE_20
                        osc_stopped <= oscillator_sleep_bit;
                    end
                end
                S_PD: begin
                    if (wake_any) begin
                        wake_irq_pending <= 1'b1;
                        wake_source <= {wake_ext0, wake_spi, wake_interval};
                        resume_after_pd <= 1'b1; // see RULE_11
                        power_control_reg[`PCTL_PD_REQ] <= 1'b0;
                        timer_start <= 1'b1;
                        if (osc_stopped) begin
                            state <= S_XTAL;
                            timer_load <= XTAL_CYCLES[TW-1:0]; // see RULE_14
                        end else begin
                            state <= S_LOCK;
                            timer_load <= LOCK_CYCLES[TW-1:0]; // see RULE_12
                        end
                    end
                end
                S_XTAL: begin
                    if (timer_done) begin
                        state <= S_LOCK;
                        timer_start <= 1'b1;
                        timer_load <= LOCK_CYCLES[TW-1:0]; // see RULE_14
                    end
                end
                S_LOCK: begin
                    if (timer_done) begin
                        pll_locked <= 1'b1; // see RULE_20
                        state <= S_RUN;
                    end
                end
                S_PINRST: begin
                    if (reset_pin_b) begin
                        core_reset <= 1'b0; // see RULE_06
                        state <= S_LOCK;
                        timer_start <= 1'b1;
                        timer_load <= LOCK_CYCLES[TW-1:0];
                    end
                end
                default: state <= S_POR;
            endcase
            // Reset pin: control registers to defaults (wake_source kept), held while pin low
            if (!reset_pin_b && state != S_POR) begin
                state <= S_PINRST; // see RULE_06
                power_control_reg <= `RST_POWER_CONTROL;
                clock_synth_control_reg <= `RST_CLOCK_SYNTH;
                irq_enable2 <= `RST_IRQ_ENABLE2;
                pll_locked <= 1'b0;
                osc_stopped <= 1'b0;
                core_reset <= 1'b1;
                wake_irq_pending <= 1'b0;
                resume_after_pd <= 1'b0;
            end
            // Supply loss wins over all: back to power-on timing
            if (supply_bad) begin
                state <= S_POR; // see RULE_15 see RULE_16 see RULE_17
                // Reload so a stale count cannot release reset early
                timer_start <= 1'b1;
                timer_load <= POR_CYCLES[TW-1:0];
                power_control_reg <= `RST_POWER_CONTROL;
                clock_synth_control_reg <= `RST_CLOCK_SYNTH;
                irq_enable2 <= `RST_IRQ_ENABLE2;
                pll_locked <= 1'b0;
                osc_stopped <= 1'b0;
                core_reset <= 1'b1;
                wake_irq_pending <= 1'b0;
                resume_after_pd <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Clock gating and pin control
    // ----------------------------------------
    always @(posedge core_clk) begin
        if (!rst_b) begin
            pll_run <= 1'b1;
            core_clk_enable <= 1'b0;
            osc_run <= 1'b1;
            interval_counter_clk_en <= 1'b0;
            peripheral_clk_en <= 1'b0;
            core_clock_divider <=
                SYNTH_RESET[`PLL_DIV_LSB+`PLL_DIV_W-1:`PLL_DIV_LSB];
            port_hold <= 1'b0;
            dac_out_enable <= 1'b0;
            ale_force_low <= 1'b0;
            program_fetch_strobe_force_low <= 1'b0;
        end else begin
            pll_run <= (state != S_PD); // see RULE_02
            core_clk_enable <= (state != S_PD) && !core_reset; // see RULE_02
            osc_run <= !(state == S_PD && osc_stopped); // see RULE_03
            interval_counter_clk_en <= interval_irq_enable &&
                !(state == S_PD && osc_stopped); // see RULE_04
            peripheral_clk_en <= (state != S_PD) && !core_reset; // see RULE_04
            core_clock_divider <=
                clock_synth_control_reg[`PLL_DIV_LSB+`PLL_DIV_W-1:
                `PLL_DIV_LSB]; // see RULE_18
            port_hold <= (state == S_PD); // see RULE_05
            dac_out_enable <= (state != S_PD) && !core_reset; // see RULE_05
            ale_force_low <= (state == S_PD); // see RULE_05
            program_fetch_strobe_force_low <= (state == S_PD); // see RULE_05
        end
    end
endmodule

// File: verif/pdws_monitor.sv
// Port assertions for the power-down wake sequencer
`timescale 1ns/1ps
`include "pwr_seq_map.vh"
module pdws_monitor #(
    parameter POR_CYCLES = 20
) (
    // Clock, reset and bus
    input wire core_clk,
    input wire rst_b,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    // Supply, pin and source inputs
    input wire reset_pin_b,
    input wire supply_above_threshold,
    input wire supply_above_1v,
    input wire spi_irq,
    // Outputs under watch
    input wire core_reset,
    input wire wake_irq_pending,
    input wire [2:0] wake_source,
    input wire resume_after_pd,
    input wire pll_run,
    input wire core_clk_enable,
    input wire osc_run,
    input wire interval_counter_clk_en,
    input wire port_hold,
    input wire ale_force_low,
    input wire program_fetch_strobe_force_low
);
// ----------------------------------------
// Helper and properties
// ----------------------------------------
// Saturates so a long pin reset cannot wrap it
reg [23:0] por_cnt;
always @(posedge core_clk) begin
    if (!rst_b || !supply_above_threshold || !supply_above_1v) begin
        por_cnt <= 24'h000000;
    end else if (core_reset && por_cnt != 24'hFFFFFF) begin
        por_cnt <= por_cnt + 24'h000001;
    end
end
default clocking @(posedge core_clk); endclocking
default disable iff (!rst_b);
a_pd_clocks_stop: assert property (
    port_hold |-> !pll_run && !core_clk_enable)
    else $error("clock running in power-down");
a_pd_strobes_low: assert property (
    port_hold |-> ale_force_low && program_fetch_strobe_force_low)
    else $error("strobes not held low in power-down");
a_interval_needs_osc: assert property (
    interval_counter_clk_en |-> osc_run)
    else $error("interval counter clocked without oscillator");
a_supply_loss_reset: assert property (
    $fell(supply_above_threshold) |-> ##[1:2] core_reset)
    else $error("no reset on supply loss");
a_decay_reset: assert property (
    $fell(supply_above_1v) |-> ##[1:2] core_reset)
    else $error("no reset on supply decay");
a_pin_reset_hold: assert property (
    !reset_pin_b |-> ##[1:2] core_reset)
    else $error("reset pin ignored");
a_por_release_time: assert property (
    $fell(core_reset) |-> por_cnt >= POR_CYCLES)
    else $error("reset released before timer ran out");
a_lock_clear_pd: assert property (
    psel && penable && !pwrite && paddr == `ADDR_CLOCK_SYNTH && port_hold
    |-> !prdata[`PLL_LOCK_BIT])
    else $error("lock flag set in power-down");
a_wake_resume: assert property (
    $rose(wake_irq_pending) |-> ##[0:2] (resume_after_pd && !port_hold))
    else $error("wake did not leave power-down");
a_spi_wake_cause: assert property (
    $rose(wake_irq_pending) && wake_source[1] |-> $past(spi_irq))
    else $error("serial wake without its interrupt");
endmodule
bind power_down_wake_sequencer pdws_monitor #(.POR_CYCLES(POR_CYCLES)) mon (
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .reset_pin_b(reset_pin_b), .supply_above_1v(supply_above_1v),
    .supply_above_threshold(supply_above_threshold), .spi_irq(spi_irq),
    .core_reset(core_reset), .wake_irq_pending(wake_irq_pending),
    .wake_source(wake_source), .resume_after_pd(resume_after_pd),
    .pll_run(pll_run), .core_clk_enable(core_clk_enable),
    .osc_run(osc_run), .interval_counter_clk_en(interval_counter_clk_en),
    .port_hold(port_hold), .ale_force_low(ale_force_low),
    .program_fetch_strobe_force_low(program_fetch_strobe_force_low)
);

// File: verif/core_wake_model.sv
// Behavioural core and wake-source model for the sequencer bench
`timescale 1ns/1ps
module core_wake_model (
    // Clock and bench control
    input wire core_clk,
    input wire [2:0] request,
    input wire slow,
    // Sequencer side
    input wire wake_irq_pending,
    output reg [2:0] irq_lines = 3'h0,
    output reg core_reti = 1'b0
);
// ----------------------------------------
// Service routine
// ----------------------------------------
reg [3:0] wait_cnt = 4'h0;
reg served = 1'b0;
// Two ISR lengths so prompt and slow returns are both seen
always @(posedge core_clk) begin
    core_reti <= 1'b0;
    if (request == 3'h0) begin
        served <= 1'b0;
    end
    if (wake_irq_pending && wait_cnt == (slow ? 4'h8 : 4'h1)) begin
        served <= 1'b1;
        core_reti <= 1'b1;
        wait_cnt <= 4'h0;
    end else if (wake_irq_pending) begin
        wait_cnt <= wait_cnt + 4'h1;
    end else begin
        wait_cnt <= 4'h0;
    end
    // ISR clears its source the cycle after returning
    irq_lines <= served ? 3'h0 : request;
end
endmodule

// File: verif/power_down_wake_sequencer_tb_top.sv
// Self-checking bench for the power-down wake sequencer
`timescale 1ns/1ps
`include "pwr_seq_map.vh"
module power_down_wake_sequencer_tb_top;
// ----------------------------------------
// Signals and tables
// ----------------------------------------
localparam [23:0] IE2_T = 24'hA0A4A1;
localparam [23:0] PCTL_T = 24'h22020A;
localparam [8:0] RIGHT_T = 9'b100_001_010;
localparam [8:0] WRONG_T = 9'b001_010_100;
reg core_clk = 1'b0;
reg rst_b, psel, penable, pwrite, reset_pin_b, slow, err;
reg supply_above_threshold, supply_above_1v, ext0_irq_enable;
reg [11:0] paddr;
reg [31:0] pwdata, rd;
reg [2:0] request;
wire pready, pslverr, core_reti, core_reset, wake_irq_pending, pll_run;
wire resume_after_pd, core_clk_enable, osc_run, port_hold, ale_force_low;
wire interval_counter_clk_en, peripheral_clk_en, dac_out_enable;
wire program_fetch_strobe_force_low;
wire [31:0] prdata;
wire [2:0] wake_source, core_clock_divider, irq_lines;
integer mismatches = 0, comparisons = 0, i, n, cyc;
time t0;
always #50 core_clk = ~core_clk;
power_down_wake_sequencer #(
    .POR_CYCLES(20), .LOCK_CYCLES(10), .XTAL_CYCLES(30)
) DUT (
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .reset_pin_b(reset_pin_b),
    .supply_above_threshold(supply_above_threshold),
    .supply_above_1v(supply_above_1v), .ext0_irq_enable(ext0_irq_enable),
    .interval_counter_irq(irq_lines[0]), .spi_irq(irq_lines[1]),
    .external_irq_zero(irq_lines[2]), .core_reti(core_reti),
    .core_reset(core_reset), .wake_irq_pending(wake_irq_pending),
    .wake_source(wake_source), .resume_after_pd(resume_after_pd),
    .pll_run(pll_run), .core_clk_enable(core_clk_enable), .osc_run(osc_run),
    .interval_counter_clk_en(interval_counter_clk_en),
    .peripheral_clk_en(peripheral_clk_en),
    .core_clock_divider(core_clock_divider), .port_hold(port_hold),
    .dac_out_enable(dac_out_enable), .ale_force_low(ale_force_low),
    .program_fetch_strobe_force_low(program_fetch_strobe_force_low)
);
core_wake_model partner (
    .core_clk(core_clk), .request(request), .slow(slow),
    .wake_irq_pending(wake_irq_pending), .irq_lines(irq_lines),
    .core_reti(core_reti)
);
task chk(input string what, input [31:0] exp, input [31:0] got);
    begin
        comparisons = comparisons + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    end
endtask
task apb(input wr, input [11:0] a, input [31:0] d);
    begin
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    end
endtask
task pause(input integer c);
    begin
        repeat (c) @(posedge core_clk);
        @(negedge core_clk);
    end
endtask
// Polls status; lock may take thousands of cycles at full counts
task wait_run;
    begin
        t0 = $time;
        rd = 32'h0;
        n = 0;
        while (rd[2:0] !== 3'h1 && n < 400) begin
            apb(1'b0, `ADDR_STATUS, 32'h0);
            n = n + 1;
        end
        cyc = ($time - t0) / 100;
        chk("status", 32'h1, rd);
    end
endtask
task check_defaults;
    begin
        apb(1'b0, `ADDR_POWER_CONTROL, 32'h0);
        chk("pctl", 32'h00, rd);
        apb(1'b0, `ADDR_CLOCK_SYNTH, 32'h0);
        chk("synth", 32'h43, rd);
        apb(1'b0, `ADDR_IRQ_ENABLE2, 32'h0);
        chk("ie2", 32'hA0, rd);
        chk("divider", 32'h3, core_clock_divider);
    end
endtask
task end_of_test;
    begin
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    end
endtask
// ----------------------------------------
// Sequence
// ----------------------------------------
initial begin
    #(100 * 20000);
    mismatches = mismatches + 1;
    end_of_test;
end
initial begin
    {rst_b, psel, penable, pwrite, slow, ext0_irq_enable} = 6'h00;
    {reset_pin_b, supply_above_threshold, supply_above_1v} = 3'h7;
    paddr = 12'h000;
    pwdata = 32'h0;
    request = 3'h0;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    wait_run;
    chk("por_time", 32'h1, cyc >= 30);
    check_defaults;
    apb(1'b0, 12'h014, 32'h0);
    chk("unmapped", 32'h100, {err, rd[7:0]});
    apb(1'b1, `ADDR_CLOCK_SYNTH, 32'h05);
    pause(1);
    chk("divider", 32'h5, core_clock_divider);
    apb(1'b1, `ADDR_CLOCK_SYNTH, 32'h03);
    for (i = 0; i < 3; i = i + 1) begin
        ext0_irq_enable <= (i == 2);
        slow <= i[0];
        apb(1'b1, `ADDR_IRQ_ENABLE2, IE2_T[8*i +: 8]);
        apb(1'b1, `ADDR_POWER_CONTROL, PCTL_T[8*i +: 8]);
        pause(2);
        chk("pd_gates", 32'h2B, {pll_run, core_clk_enable, osc_run,
            peripheral_clk_en, port_hold, dac_out_enable, ale_force_low,
            program_fetch_strobe_force_low});
        apb(1'b0, `ADDR_CLOCK_SYNTH, 32'h0);
        chk("lock_pd", 32'h03, rd);
        request <= WRONG_T[3*i +: 3];
        pause(6);
        chk("refused", 32'h1, port_hold);
        @(posedge core_clk);
        request <= RIGHT_T[3*i +: 3];
        n = 0;
        while (wake_irq_pending !== 1'b1 && n < 40) begin
            @(negedge core_clk);
            n = n + 1;
        end
        chk("wake_src", RIGHT_T[3*i +: 3], wake_source);
        chk("resume", 32'h1, resume_after_pd);
        @(posedge core_clk);
        request <= 3'h0;
        wait_run;
        chk("lock_time", 32'h1, cyc >= 10);
        apb(1'b0, `ADDR_CLOCK_SYNTH, 32'h0);
        chk("lock_after", 32'h43, rd);
        apb(1'b0, `ADDR_POWER_CONTROL, 32'h0);
        chk("pd_clear", PCTL_T[8*i +: 8] & 8'hFD, rd);
        chk("pending", 32'h0, wake_irq_pending);
    end
    apb(1'b1, `ADDR_CLOCK_SYNTH, 32'h83);
    apb(1'b1, `ADDR_IRQ_ENABLE2, 32'hA5);
    apb(1'b1, `ADDR_POWER_CONTROL, 32'h0A);
    pause(2);
    chk("osc_stop", 32'h0, osc_run);
    request <= 3'b001;
    pause(6);
    chk("tick_refused", 32'h1, port_hold);
    request <= 3'b010;
    wait_run;
    chk("xtal_time", 32'h1, cyc >= 40);
    request <= 3'h0;
    apb(1'b1, `ADDR_POWER_CONTROL, 32'h02);
    pause(2);
    @(posedge core_clk) reset_pin_b <= 1'b0;
    pause(3);
    chk("pin_reset", 32'h1, core_reset);
    @(posedge core_clk) reset_pin_b <= 1'b1;
    wait_run;
    check_defaults;
    apb(1'b1, `ADDR_POWER_CONTROL, 32'h02);
    pause(2);
    @(posedge core_clk) {supply_above_threshold, supply_above_1v} <= 2'b00;
    pause(3);
    chk("supply_low", 32'h1, core_reset);
    @(posedge core_clk) {supply_above_threshold, supply_above_1v} <= 2'b11;
    wait_run;
    chk("por_again", 32'h1, cyc >= 30);
    check_defaults;
    end_of_test;
end
endmodule
